// ===== logic/asu_uart.sv
/*
  Asynchronous serial transmitter/receiver with fractional baud generator,
  APB register slave, 16-entry FIFOs and infrared pulse option.
  Assumes serial_rx_line is already synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module asu_uart #(
  parameter int FIFO_DEPTH = asu_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line
);
  generate
    if (FIFO_DEPTH != 16)
    begin : g_bad_depth
      $error("asu_uart FIFO depth is fixed at 16 entries");
    end
  endgenerate

  // ==========================================================================
  // Helpers
  function automatic logic par_bit(input logic [7:0] d, input asu_pkg::asu_lcr_t l);
    if (l.sps)
      par_bit = ~l.eps;
    else
      par_bit = l.eps ? ^d : ~^d;
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == asu_pkg::ADDR_DATA) || (a == asu_pkg::ADDR_STAT) ||
                 (a == asu_pkg::ADDR_FLAG) || (a == asu_pkg::ADDR_IBRD) ||
                 (a == asu_pkg::ADDR_FBRD) || (a == asu_pkg::ADDR_LCR)  ||
                 (a == asu_pkg::ADDR_CTL);
  endfunction

  // ==========================================================================
  // Registers and shared nets
  asu_pkg::asu_div_cfg_t cfg_q;
  asu_pkg::asu_rx_ent_t  rx_head;
  asu_pkg::asu_rx_ent_t  rx_ent;
  asu_pkg::asu_state_t   tx_st_q;
  asu_pkg::asu_state_t   rx_st_q;
  logic [15:0] ctl_q;
  logic [15:0] ibrd_q;
  logic [5:0]  fbrd_q;
  logic        setup;
  logic        access;
  logic        rd_valid_q;
  logic        oe_stat_q;
  logic        ctl_en;
  logic        ir_mode;
  logic [7:0]  tx_head;
  logic        tx_valid;
  logic        tx_full;
  logic        tx_wr;
  logic        tx_go;
  logic        rx_valid;
  logic        rx_full;
  logic        rx_pop;
  logic        rx_push;
  logic        busy;
  logic [7:0]  flags;
  logic        lcr_wr;

  assign ctl_en = ctl_q[asu_pkg::CTL_EN_BIT];
  assign ir_mode = ctl_q[asu_pkg::CTL_IR_BIT];
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign lcr_wr = access && pwrite && (paddr == asu_pkg::ADDR_LCR);
  assign tx_wr  = access && pwrite && (paddr == asu_pkg::ADDR_DATA);
  assign rx_pop = access && !pwrite && (paddr == asu_pkg::ADDR_DATA) && rd_valid_q;
  assign busy   = tx_valid || (tx_st_q != asu_pkg::ST_IDLE);

  always_comb
  begin
    flags = 8'h00;
    flags[asu_pkg::FLAG_BUSY] = busy;
    flags[asu_pkg::FLAG_RXFE] = !rx_valid;
    flags[asu_pkg::FLAG_TXFF] = tx_full;
    flags[asu_pkg::FLAG_RXFF] = rx_full;
    flags[asu_pkg::FLAG_TXFE] = !tx_valid;
  end

  // ==========================================================================
  // APB slave: one wait-free answer, data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !known_addr(paddr);
      if (setup)
      begin
        rd_valid_q <= rx_valid;
        case (paddr)
          asu_pkg::ADDR_DATA: prdata <= rx_valid ? {20'h0_0000, rx_head} : 32'h0000_0000;
          asu_pkg::ADDR_STAT: prdata <= {28'h000_0000, oe_stat_q, 3'h0};
          asu_pkg::ADDR_FLAG: prdata <= {24'h00_0000, flags};
          asu_pkg::ADDR_IBRD: prdata <= {16'h0000, ibrd_q};
          asu_pkg::ADDR_FBRD: prdata <= {26'h000_0000, fbrd_q};
          asu_pkg::ADDR_LCR:  prdata <= {24'h00_0000, cfg_q.lcr};
          asu_pkg::ADDR_CTL:  prdata <= {16'h0000, ctl_q};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-visible configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q  <= asu_pkg::CTL_RESET;
      ibrd_q <= 16'h0000;
      fbrd_q <= 6'h00;
      cfg_q  <= {16'h0000, 6'h00, asu_pkg::LCR_RESET};
    end
    else if (access && pwrite)
    begin
      case (paddr)
        asu_pkg::ADDR_CTL:  ctl_q  <= pwdata[15:0];
        asu_pkg::ADDR_IBRD: ibrd_q <= pwdata[15:0];
        asu_pkg::ADDR_FBRD: fbrd_q <= pwdata[5:0];
        // Divisors take effect only with the line-control write
        asu_pkg::ADDR_LCR:  cfg_q  <= {ibrd_q, fbrd_q, pwdata[7:0]};
        default:            ctl_q  <= ctl_q;
      endcase
    end
  end

  // ==========================================================================
  // Oversample tick: whole divisor plus a stretch cycle on fraction carry
  logic [15:0] bcnt_q;
  logic [5:0]  acc_q;
  logic [6:0]  acc_sum;
  logic        tick_q;

  assign acc_sum = {1'b0, acc_q} + {1'b0, cfg_q.frac};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bcnt_q <= 16'h0000;
      acc_q  <= 6'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (bcnt_q != 16'h0000)
        bcnt_q <= bcnt_q - 16'h0001;
      else if (cfg_q.whole != 16'h0000)
      begin
        tick_q <= 1'b1;
        acc_q  <= acc_sum[5:0];
        bcnt_q <= cfg_q.whole - 16'h0001 + {15'h0000, acc_sum[6]};
      end
    end
  end

  // ==========================================================================
  // Transmitter
  logic [3:0] tx_tick_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic       tx_par_q;
  logic       tx_stop2_q;
  logic       tx_lvl;
  logic       tx_end;
  logic [2:0] tx_last;

  assign tx_last = {1'b0, cfg_q.lcr.wlen} + 3'h4;
  assign tx_end  = tick_q && (tx_tick_q == asu_pkg::OVS_LAST);
  // Enable is looked at only between characters, so a frame always completes
  assign tx_go   = ctl_en && ctl_q[asu_pkg::CTL_TX_ON_BIT] && tx_valid;

  always_comb
  begin
    case (tx_st_q)
      asu_pkg::ST_START: tx_lvl = 1'b0;
      asu_pkg::ST_DATA:  tx_lvl = tx_sh_q[tx_bit_q];
      asu_pkg::ST_PAR:   tx_lvl = tx_par_q;
      default:           tx_lvl = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q    <= asu_pkg::ST_IDLE;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end
    else if (tx_st_q == asu_pkg::ST_IDLE)
    begin
      if (tx_go)
      begin
        tx_st_q    <= asu_pkg::ST_START;
        tx_sh_q    <= tx_head;
        tx_par_q   <= par_bit(tx_head, cfg_q.lcr);
        tx_tick_q  <= 4'h0;
        tx_bit_q   <= 3'h0;
        tx_stop2_q <= 1'b0;
      end
    end
    else if (tick_q)
    begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_end)
      begin
        case (tx_st_q)
          asu_pkg::ST_START: tx_st_q <= asu_pkg::ST_DATA;
          asu_pkg::ST_DATA:
          begin
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == tx_last)
              tx_st_q <= cfg_q.lcr.pen ? asu_pkg::ST_PAR : asu_pkg::ST_STOP;
          end
          asu_pkg::ST_PAR:   tx_st_q <= asu_pkg::ST_STOP;
          asu_pkg::ST_STOP:
          begin
            tx_stop2_q <= 1'b1;
            if (!cfg_q.lcr.stp2 || tx_stop2_q)
              tx_st_q <= asu_pkg::ST_IDLE;
          end
          default:           tx_st_q <= asu_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Infrared mode sends a short high pulse for each zero bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_tx_line <= 1'b1;
    else if (ir_mode)
      serial_tx_line <= !(tx_lvl && !cfg_q.lcr.brk) && (tx_tick_q < asu_pkg::IR_PULSE);
    else
      serial_tx_line <= tx_lvl && !cfg_q.lcr.brk;
  end

  // ==========================================================================
  // Receiver
  logic [3:0] rx_tick_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_pb_q;
  logic       rx_pe_q;
  logic       oe_pend_q;
  logic [3:0] ir_hold_q;
  logic       rx_lvl;
  logic       rx_mid;
  logic       rx_prev_q;

  // A low infrared pulse is held as a zero for the rest of the bit
  assign rx_lvl = ir_mode ? (serial_rx_line && ir_hold_q == 4'h0) : serial_rx_line;
  assign rx_mid = tick_q && (rx_tick_q == asu_pkg::OVS_LAST);
  assign rx_push = rx_mid && (rx_st_q == asu_pkg::ST_STOP);

  always_comb
  begin
    rx_ent.oe   = oe_pend_q;
    rx_ent.be   = !rx_lvl && (rx_sh_q == 8'h00) && !rx_pb_q;
    rx_ent.pe   = rx_pe_q;
    rx_ent.fe   = !rx_lvl;
    rx_ent.data = rx_sh_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ir_hold_q <= 4'h0;
    else if (!serial_rx_line)
      ir_hold_q <= asu_pkg::OVS_LAST;
    else if (tick_q && ir_hold_q != 4'h0)
      ir_hold_q <= ir_hold_q - 4'h1;
  end

  // Start needs a falling edge: a low stop bit must not restart the receiver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= rx_lvl;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q   <= asu_pkg::ST_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_pb_q   <= 1'b0;
      rx_pe_q   <= 1'b0;
    end
    else
    begin
      case (rx_st_q)
        asu_pkg::ST_IDLE:
          if (ctl_en && ctl_q[asu_pkg::CTL_RX_ON_BIT] && rx_prev_q && !rx_lvl)
          begin
            rx_st_q   <= asu_pkg::ST_START;
            rx_tick_q <= 4'h0;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_pb_q   <= 1'b0;
            rx_pe_q   <= 1'b0;
          end
        asu_pkg::ST_START:
          if (tick_q)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == asu_pkg::START_SAMPLE)
            begin
              rx_tick_q <= 4'h0;
              rx_st_q   <= rx_lvl ? asu_pkg::ST_IDLE : asu_pkg::ST_DATA;
            end
          end
        default:
          if (tick_q)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_mid)
            begin
              case (rx_st_q)
                asu_pkg::ST_DATA:
                begin
                  rx_sh_q[rx_bit_q] <= rx_lvl;
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == tx_last)
                    rx_st_q <= cfg_q.lcr.pen ? asu_pkg::ST_PAR : asu_pkg::ST_STOP;
                end
                asu_pkg::ST_PAR:
                begin
                  rx_pb_q <= rx_lvl;
                  rx_pe_q <= rx_lvl != par_bit(rx_sh_q, cfg_q.lcr);
                  rx_st_q <= asu_pkg::ST_STOP;
                end
                default: rx_st_q <= asu_pkg::ST_IDLE;
              endcase
            end
          end
      endcase
    end
  end

  // Overrun: the new character is dropped and flagged on the next one stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_pend_q <= 1'b0;
      oe_stat_q <= 1'b0;
    end
    else
    begin
      if (rx_push && rx_full)
        oe_pend_q <= 1'b1;
      else if (rx_push)
        oe_pend_q <= 1'b0;
      if (rx_push && rx_full)
        oe_stat_q <= 1'b1;
      else if (access && pwrite && paddr == asu_pkg::ADDR_STAT)
        oe_stat_q <= 1'b0;
    end
  end

  // ==========================================================================
  // FIFOs
  asu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk     (pclk),
    .rst_n   (presetn),
    .single  (!cfg_q.lcr.fifo_on),
    .wr_en   (tx_wr),
    .wr_data (pwdata[7:0]),
    .rd_en   (tx_st_q == asu_pkg::ST_IDLE && tx_go),
    .rd_data (tx_head),
    .valid   (tx_valid),
    .full    (tx_full)
  );

  asu_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk     (pclk),
    .rst_n   (presetn),
    .single  (!cfg_q.lcr.fifo_on),
    .wr_en   (rx_push),
    .wr_data (rx_ent),
    .rd_en   (rx_pop),
    .rd_data (rx_head),
    .valid   (rx_valid),
    .full    (rx_full)
  );

  // ==========================================================================
  // Assertions
  a_reset_enables: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ctl_q[asu_pkg::CTL_TX_ON_BIT] && ctl_q[asu_pkg::CTL_RX_ON_BIT])
    else $error("tx/rx enables not set after reset");
  a_frame_finish: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q != asu_pkg::ST_IDLE && !ctl_en && !(tx_st_q == asu_pkg::ST_STOP && tx_end))
    |=> tx_st_q != asu_pkg::ST_IDLE)
    else $error("frame cut short by disable");
  a_tx_level: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q != asu_pkg::ST_IDLE && !ir_mode && !cfg_q.lcr.brk)
    |=> serial_tx_line == $past(tx_lvl))
    else $error("tx line does not follow frame bit");
  a_tx_start: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q == asu_pkg::ST_IDLE && tx_go) |=> tx_st_q == asu_pkg::ST_START
    ##1 (!serial_tx_line || ir_mode || cfg_q.lcr.brk))
    else $error("frame did not start with pending data");
  a_busy_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> $past(tx_st_q) == asu_pkg::ST_STOP && !tx_valid)
    else $error("busy fell before stop bits ended");
  a_start_reject: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_st_q == asu_pkg::ST_START && tick_q && rx_tick_q == asu_pkg::START_SAMPLE && rx_lvl)
    |=> rx_st_q == asu_pkg::ST_IDLE)
    else $error("false start bit accepted");
  a_div_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q != $past(cfg_q)) |-> $past(lcr_wr))
    else $error("divisor changed without line-control write");
  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_q && cfg_q.whole > 16'h0001) |=> !tick_q)
    else $error("oversample tick too close");
  a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_push && rx_full) |=> oe_stat_q && oe_pend_q && $stable(rx_head))
    else $error("overrun not flagged or entry overwritten");
  a_frame_error: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_push && !rx_valid) |=> rx_head.fe == !$past(rx_lvl))
    else $error("stored framing flag does not match stop sample");

  c_tx_frame: cover property (@(posedge pclk) disable iff (!presetn)
    tx_st_q == asu_pkg::ST_STOP ##1 tx_st_q == asu_pkg::ST_IDLE);
  c_rx_store: cover property (@(posedge pclk) disable iff (!presetn) rx_push && !rx_full);
  c_overrun:  cover property (@(posedge pclk) disable iff (!presetn) rx_push && rx_full);
endmodule // asu_uart
`default_nettype wire

// ===== include/asu_pkg.sv
/*
  Shared constants and types of the asynchronous serial core: register map,
  control and flag bit positions, reset values, FIFO entry layout, states.
  Assumes a 32-bit APB master and a single system clock.
*/
package asu_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_DATA  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_FLAG  = 8'h08;
  localparam logic [7:0] ADDR_IBRD  = 8'h0C;
  localparam logic [7:0] ADDR_FBRD  = 8'h10;
  localparam logic [7:0] ADDR_LCR   = 8'h14;
  localparam logic [7:0] ADDR_CTL   = 8'h18;

  // ==========================================================================
  // Control and flag bits
  localparam int CTL_EN_BIT  = 0;
  localparam int CTL_IR_BIT  = 1;
  localparam int CTL_TX_ON_BIT = 8;
  localparam int CTL_RX_ON_BIT = 9;
  localparam logic [15:0] CTL_RESET = 16'h0300;
  localparam logic [7:0]  LCR_RESET = 8'h00;
  localparam int FLAG_BUSY = 3;
  localparam int FLAG_RXFE = 4;
  localparam int FLAG_TXFF = 5;
  localparam int FLAG_RXFF = 6;
  localparam int FLAG_TXFE = 7;

  // ==========================================================================
  // Timing in oversample ticks and FIFO depth
  localparam logic [3:0] OVS_LAST     = 4'hF;
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [3:0] IR_PULSE     = 4'h3;
  localparam int         FIFO_DEPTH   = 16;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       sps;
    logic [1:0] wlen;
    logic       fifo_on;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } asu_lcr_t;

  typedef struct packed {
    logic [15:0] whole;
    logic [5:0]  frac;
    asu_lcr_t    lcr;
  } asu_div_cfg_t;

  typedef struct packed {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } asu_rx_ent_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } asu_state_t;

endpackage

// ===== logic/asu_fifo.sv
/*
  Small FIFO memory with registered head word and a single-entry mode.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module asu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Mode
  input  wire logic             single,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  valid,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("asu_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      cnt_q;
  logic             wr_ok;
  logic             rd_ok;

  assign valid = (cnt_q != '0);
  // Single-entry mode behaves as a plain holding register
  assign full  = single ? valid : (cnt_q == (AW+1)'(DEPTH));
  assign wr_ok = wr_en && !full;
  assign rd_ok = rd_en && valid;

  always_ff @(posedge clk)
  begin
    if (wr_ok)
      mem[wptr_q] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      rd_data <= '0;
    end
    else
    begin
      if (wr_ok)
        wptr_q <= wptr_q + 1'b1;
      if (rd_ok)
        rptr_q <= rptr_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
      // Head word tracks the read pointer so it is valid with no latency
      if (wr_ok && (cnt_q == '0 || (cnt_q == (AW+1)'(1) && rd_ok)))
        rd_data <= wr_data;
      else if (rd_ok)
        rd_data <= mem[rptr_q + 1'b1];
    end
  end
endmodule // asu_fifo
`default_nettype wire

// ===== tb/asu_serial_peer.sv
/*
  Remote serial device: records frames seen on the transmit line and
  sends frames or short glitches on the receive line.
  Assumes 8 data bits with one parity bit and BIT_CLKS clocks per bit.
*/
`timescale 1ns/10ps
`default_nettype none
module asu_serial_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [10:0] frames[$];

  // ==========================================================
  // Capture, mid-bit sampling of start, data, parity, stop
  initial
  begin : cap
    logic [10:0] f;
    forever
    begin
      @(negedge tx_line);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 11; i++)
      begin
        f[i] = tx_line;
        // No wait after stop: next start may follow at once
        if (i < 10) repeat (BIT_CLKS) @(posedge clk);
      end
      frames.push_back(f);
    end
  end

  // ==========================================================
  // Stimulus; idle line is pulled high
  initial rx_line = 1'b1;

  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  task automatic low_pulse(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask
endmodule // asu_serial_peer
`default_nettype wire

// ===== tb/tb.sv
/*
  Self-checking bench for asu_uart: APB register traffic and serial frames.
  Assumes the package, the design files and the serial peer compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // Whole divisor 2, fraction 0: tick every 2 clocks
  localparam int BIT_CLKS = 32;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_rx_line;
  logic        serial_tx_line;
  logic [31:0] rd;
  logic        slv_err;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  asu_uart i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line));
  asu_serial_peer #(.BIT_CLKS(BIT_CLKS)) i_peer (.clk(pclk), .tx_line(serial_tx_line),
    .rx_line(serial_rx_line));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Run is some 3300 cycles; anything far beyond is a hang
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // APB master; an idle cycle separates transfers, so psel is never
  // lowered and raised in one time step. Answer taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] tx_b[3];
    tx_b = '{8'hA5, 8'h3C, 8'h0F};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(asu_pkg::ADDR_CTL, 32'h300);
    rd_chk(asu_pkg::ADDR_FLAG, 32'h90);
    rd_chk(8'hFC, 32'h0);
    check({31'h0, slv_err}, 32'h1);
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h300);
    apb(1'b1, asu_pkg::ADDR_FBRD, 32'h0);
    apb(1'b1, asu_pkg::ADDR_IBRD, 32'h2);
    rd_chk(asu_pkg::ADDR_LCR, 32'h0);
    // Eight bits, even parity, FIFOs on
    apb(1'b1, asu_pkg::ADDR_LCR, 32'h76);
    rd_chk(asu_pkg::ADDR_LCR, 32'h76);
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h301);
    apb(1'b1, asu_pkg::ADDR_DATA, {24'h0, tx_b[0]});
    // Disable while the first character is on the line
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h300);
    rd_chk(asu_pkg::ADDR_FLAG, 32'h98);
    while (i_peer.frames.size() < 1) @(posedge pclk);
    repeat (BIT_CLKS) @(posedge pclk);
    rd_chk(asu_pkg::ADDR_FLAG, 32'h90);
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h301);
    apb(1'b1, asu_pkg::ADDR_DATA, {24'h0, tx_b[1]});
    apb(1'b1, asu_pkg::ADDR_DATA, {24'h0, tx_b[2]});
    while (i_peer.frames.size() < 3) @(posedge pclk);
    for (int k = 0; k < 3; k++)
      check({21'h0, i_peer.frames[k]}, {21'h0, 1'b1, ^tx_b[k], tx_b[k], 1'b0});
    i_peer.send(8'h5A, 1'b0, 1'b1);
    rd_chk(asu_pkg::ADDR_DATA, 32'h05A);
    i_peer.send(8'h5A, 1'b1, 1'b1);
    rd_chk(asu_pkg::ADDR_DATA, 32'h25A);
    i_peer.send(8'h5A, 1'b0, 1'b0);
    rd_chk(asu_pkg::ADDR_DATA, 32'h15A);
    // Low for 3 ticks only: gone before the eighth tick
    i_peer.low_pulse(6);
    repeat (2 * BIT_CLKS) @(posedge pclk);
    rd_chk(asu_pkg::ADDR_FLAG, 32'h90);
    // FIFOs off: one holding entry, so a second character overruns
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h300);
    apb(1'b1, asu_pkg::ADDR_LCR, 32'h66);
    apb(1'b1, asu_pkg::ADDR_CTL, 32'h301);
    i_peer.send(8'h81, 1'b0, 1'b1);
    @(posedge pclk);
    i_peer.send(8'h42, 1'b0, 1'b1);
    rd_chk(asu_pkg::ADDR_STAT, 32'h8);
    rd_chk(asu_pkg::ADDR_DATA, 32'h081);
    i_peer.send(8'h24, 1'b0, 1'b1);
    rd_chk(asu_pkg::ADDR_DATA, 32'h824);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
